// ===== logic/scl_pkg.sv
/*
 * package for the serial channel configuration latch block: latch map,
 * bit positions, reset images, bus answer codes and carrier types.
 * assumes a single 125 mhz clock domain for the register side.
 */
package scl_pkg;

	// ==========================================================
	// geometry
	localparam int NUM_CH    = 4;
	localparam int NUM_ADDR  = 16;
	localparam int ADDR_W    = 6;

	// ==========================================================
	// latch index map; bus address equals the index
	localparam logic [3:0] IDX_STAT_RX   = 4'h0;
	localparam logic [3:0] IDX_STAT_TX   = 4'h1;
	localparam logic [3:0] IDX_DYN       = 4'h2;
	localparam logic [3:0] IDX_GL_RX     = 4'hc;
	localparam logic [3:0] IDX_GL_TX     = 4'hd;
	localparam logic [3:0] IDX_GL_DYN    = 4'he;
	localparam logic [3:0] IDX_MASK      = 4'hf;
	localparam logic [3:0] IDX_STATUS_HI = 4'hf;
	localparam logic [2:0] BANKS_PER_CH  = 3'h3;
	// status register sits above the latch map
	localparam logic [5:0] ADDR_STATUS   = 6'h10;

	// ==========================================================
	// bit positions, dynamic bank
	localparam int B_GLEN      = 0;
	localparam int B_PABRST    = 1;
	localparam int B_OE1       = 2;
	localparam int B_OE2       = 3;
	localparam int B_TXST      = 4;
	localparam int B_RXST      = 5;
	localparam int B_RXPWR     = 6;
	localparam int B_RFEN      = 7;
	// static tx bank
	localparam int B_TXRATE    = 1;
	localparam int B_TXCKSEL   = 2;

	// ==========================================================
	// reset images
	localparam logic [7:0] RST_STAT_RX = 8'h00_bf;
	localparam logic [7:0] RST_STAT_TX = 8'h00_ad;
	localparam logic [7:0] RST_DYN     = 8'h00_b3;
	localparam logic [7:0] RST_MASK    = 8'h00_ff;
	localparam logic [7:0] RST_GLOBAL  = 8'h00_00;

	// ==========================================================
	// multipliers and bus answers
	localparam logic [4:0]  MULT_LOW     = 5'h0_0a;
	localparam logic [4:0]  MULT_HIGH    = 5'h0_14;
	localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_DECERR  = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACK  = 2'b01
	} scl_state_t;

	// per-channel control outputs toward the analog/pll side
	typedef struct packed {
		logic [4:0] pll_mult;
		logic       txclk_double;
		logic       ddr_capture;
		logic       framer_enable;
		logic       rx_power;
		logic       rx_selftest_en;
		logic       tx_selftest_en;
		logic       primary_drive;
		logic       secondary_drive;
		logic       channel_logic_on;
		logic       recenter_pulse;
		logic       speed_conflict;
	} scl_ch_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
	} scl_req_t;

endpackage

// ===== logic/scl_config_latches.sv
/*
 * four-channel configuration latch bank behind an avalon-mm slave.
 * per channel: static rx, static tx and dynamic banks plus global banks.
 * assumes tx_input_clock and speed_range_select are asynchronous pins.
 */
// Local design decisions: register access over Avalon-MM and the register offsets.
// Operation
// - rate cleared: pll multiplies reference by ten
// - rate cleared: output clock at reference rate
// - rate set: pll multiplies reference by twenty
// - rate set: output clock twice reference
// - clock select and rate: capture both edges
// - reframe enabled: framer aligns per mode
// - reframe cleared: frame offset never changes
// - rx enable: zero powers down rx pll
// - rx selftest latch: zero enables selftest
// - tx selftest latch: zero enables selftest
// - secondary driver enable, reset zero
// - primary driver enable, reset zero
// - disabled driver is powered down
// - both drivers off: channel logic off
// - device reset disables all drivers
// - writing zero recenters phase buffer
// - recenter synchronised on tx input clock
// - recenter latch clears itself
// - participation bit gates global writes
// - force bit overrides participation bits
`timescale 1ns/1ps

module scl_config_latches
	import scl_pkg::*;
(
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]     avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	output logic [1:0]                 avs_response,
	// asynchronous channel pins
	input  wire logic [NUM_CH-1:0]     tx_input_clock,
	input  wire logic [NUM_CH-1:0]     speed_range_select,
	// per-channel controls
	output scl_ch_ctrl_t [NUM_CH-1:0]  ch_ctrl
);

	// ==========================================================
	// state
	typedef struct packed {
		scl_state_t                        st;
		logic [NUM_ADDR-1:0][7:0]          lat;
		logic [31:0]                       rdata;
		logic [1:0]                        resp;
		logic                              waitreq;
		logic [NUM_CH-1:0]                 spd_s1;
		logic [NUM_CH-1:0]                 spd_s2;
		logic [NUM_CH-1:0]                 tck_s1;
		logic [NUM_CH-1:0]                 tck_s2;
		logic [NUM_CH-1:0]                 tck_s3;
		logic [NUM_CH-1:0]                 rc_pend;
		scl_ch_ctrl_t [NUM_CH-1:0]         ctrl;
	} scl_regs_t;

	scl_regs_t s_q;
	scl_regs_t s_d;

	function automatic logic [7:0] reset_image(input int idx);
		if (idx == int'(IDX_MASK))
			return RST_MASK;
		if (idx >= int'(IDX_GL_RX))
			return RST_GLOBAL;
		case (idx % 3)
			0:       return RST_STAT_RX;
			1:       return RST_STAT_TX;
			default: return RST_DYN;
		endcase
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] nw, input logic [7:0] msk);
		return (old & ~msk) | (nw & msk);
	endfunction

	logic req_rd;
	logic req_wr;
	logic [3:0] widx;
	assign req_rd = avs_read && (s_q.st == ST_IDLE);
	assign req_wr = avs_write && (s_q.st == ST_IDLE);
	assign widx   = avs_address[3:0];

	// ==========================================================
	// next state
	always_comb begin
		logic [7:0] wd;
		logic [7:0] msk;
		logic       force_gl;
		int         bank;
		int         tgt;
		s_d        = s_q;
		wd         = avs_writedata[7:0];
		msk        = s_q.lat[IDX_MASK];
		force_gl   = 1'b0;
		bank       = 0;
		tgt        = 0;
		s_d.waitreq = 1'b1;
		s_d.spd_s1 = speed_range_select;
		s_d.spd_s2 = s_q.spd_s1;
		s_d.tck_s1 = tx_input_clock;
		s_d.tck_s2 = s_q.tck_s1;
		s_d.tck_s3 = s_q.tck_s2;

		// bus slave: one wait cycle, answer on the second edge
		case (s_q.st)
			ST_IDLE: begin
				if (req_rd || req_wr) begin
					s_d.st     = ST_ACK;
					s_d.waitreq = 1'b0;
					s_d.resp   = avs_address[5:4] == 2'h0 ||
						avs_address == ADDR_STATUS ? RESP_OK : RESP_DECERR;
					s_d.rdata  = UNMAPPED_RD;
					if (avs_address[5:4] == 2'h0)
						s_d.rdata = {24'h00_0000, s_q.lat[widx]};
					else if (avs_address == ADDR_STATUS)
						for (int c = 0; c < NUM_CH; c++) begin
							s_d.rdata[c]     = s_q.rc_pend[c];
							s_d.rdata[4+c]   = s_q.ctrl[c].channel_logic_on;
							s_d.rdata[8+c]   = s_q.ctrl[c].speed_conflict;
						end
				end
				if (req_wr && avs_address[5:4] == 2'h0) begin
					if (widx == IDX_MASK) begin
						s_d.lat[IDX_MASK] = wd;
					end else if (widx < IDX_GL_RX) begin
						// channel bank, masked
						s_d.lat[widx] = merge(s_q.lat[widx], wd, msk);
						// bit 1 of a dynamic bank written zero queues a recenter
						if (widx % 4'h3 == 4'h2 && msk[B_PABRST] &&
							!wd[B_PABRST])
							s_d.rc_pend[widx / 3] = 1'b1;
					end else begin
						bank     = int'(widx - IDX_GL_RX);
						force_gl = wd[B_GLEN];
						for (int c = 0; c < NUM_CH; c++) begin
							tgt = c * 3 + bank;
							// participation gate
							if (force_gl || s_q.lat[tgt][B_GLEN]) begin
								s_d.lat[tgt] = merge(s_q.lat[tgt],
									{wd[7:1], s_q.lat[tgt][B_GLEN]},
									msk);
								if (bank == 2 && msk[B_PABRST] &&
									!wd[B_PABRST])
									s_d.rc_pend[c] = 1'b1;
							end
						end
					end
				end
			end
			ST_ACK: begin
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		for (int c = 0; c < NUM_CH; c++) begin
			logic [7:0] stx;
			logic [7:0] dyn;
			logic       tck_rise;
			stx      = s_d.lat[c*3+1];
			dyn      = s_d.lat[c*3+2];
			// crossing done by tck_s1/s2, edge seen on s2/s3
			tck_rise = s_q.tck_s2[c] && !s_q.tck_s3[c];
			s_d.ctrl[c].recenter_pulse = 1'b0;
			if (s_q.rc_pend[c] && tck_rise) begin
				s_d.ctrl[c].recenter_pulse = 1'b1;
				s_d.rc_pend[c]             = 1'b0;
			end
			// latch returns to one once recentering is queued
			if (s_d.rc_pend[c] || s_q.rc_pend[c])
				s_d.lat[c*3+2][B_PABRST] = 1'b1;
			s_d.ctrl[c].pll_mult = stx[B_TXRATE] ?
				MULT_HIGH : MULT_LOW;
			s_d.ctrl[c].txclk_double = stx[B_TXRATE];
			s_d.ctrl[c].ddr_capture =
				stx[B_TXCKSEL] && stx[B_TXRATE];
			// flagged, not blocked: host must avoid it
			s_d.ctrl[c].speed_conflict =
				stx[B_TXRATE] && !s_q.spd_s2[c];
			s_d.ctrl[c].framer_enable  = dyn[B_RFEN];
			s_d.ctrl[c].rx_power       = dyn[B_RXPWR];
			s_d.ctrl[c].rx_selftest_en = !dyn[B_RXST];
			s_d.ctrl[c].tx_selftest_en = !dyn[B_TXST];
			// drivers power down when off
			s_d.ctrl[c].primary_drive   = dyn[B_OE1];
			s_d.ctrl[c].secondary_drive = dyn[B_OE2];
			s_d.ctrl[c].channel_logic_on =
				dyn[B_OE1] || dyn[B_OE2];
		end
	end

	// ==========================================================
	// registers; reset loads the init images, drivers off
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q.st     <= ST_IDLE;
			s_q.rdata  <= UNMAPPED_RD;
			s_q.resp   <= RESP_OK;
			s_q.waitreq <= 1'b1;
			s_q.spd_s1 <= '0;
			s_q.spd_s2 <= '0;
			s_q.tck_s1 <= '0;
			s_q.tck_s2 <= '0;
			s_q.tck_s3 <= '0;
			s_q.rc_pend <= '0;
			for (int i = 0; i < NUM_ADDR; i++)
				s_q.lat[i] <= reset_image(i);
			for (int c = 0; c < NUM_CH; c++) begin
				s_q.ctrl[c]                <= '0;
				s_q.ctrl[c].pll_mult       <= MULT_LOW;
				s_q.ctrl[c].framer_enable  <= 1'b1;
			end
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign avs_response    = s_q.resp;
	assign ch_ctrl         = s_q.ctrl;

	// ==========================================================
	// checks
	sequence s_dyn_wr(int c);
		avs_write && s_q.st == ST_IDLE &&
		avs_address == ADDR_W'(c*3+2);
	endsequence

	// controls are built from the next latch image, so they move together
	a_mult_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s_q.lat[1][B_TXRATE] |-> ch_ctrl[0].pll_mult == MULT_LOW)
		else $error("mult not ten with rate clear");

	a_mult_high: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.lat[1][B_TXRATE] |-> ch_ctrl[0].pll_mult == MULT_HIGH)
		else $error("mult not twenty with rate set");

	a_clk_double: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[0].txclk_double == s_q.lat[1][B_TXRATE])
		else $error("output clock rate mismatch");

	a_mult_ch3: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s_q.lat[10][B_TXRATE] |-> ch_ctrl[3].pll_mult == MULT_LOW)
		else $error("channel three mult not ten");

	a_rate_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s_q.lat[4][B_TXRATE] |-> !ch_ctrl[1].txclk_double)
		else $error("output clock doubled with rate clear");

	a_ddr_full: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.lat[7][B_TXRATE] && s_q.lat[7][B_TXCKSEL]
		|-> ch_ctrl[2].ddr_capture)
		else $error("both edge capture missing");

	a_framer_on: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.lat[2][B_RFEN] |-> ch_ctrl[0].framer_enable)
		else $error("framer not enabled");

	a_framer_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s_q.lat[11][B_RFEN] |-> !ch_ctrl[3].framer_enable)
		else $error("framer not disabled");

	a_rx_bist: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[2].rx_selftest_en == !s_q.lat[8][B_RXST])
		else $error("rx selftest enable mismatch");

	a_tx_bist: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[2].tx_selftest_en == !s_q.lat[8][B_TXST])
		else $error("tx selftest enable mismatch");

	a_sec_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[3].secondary_drive == s_q.lat[11][B_OE2])
		else $error("secondary driver enable mismatch");

	a_pri_drive: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[3].primary_drive == s_q.lat[11][B_OE1])
		else $error("primary driver enable mismatch");

	a_drive_down: assert property (@(posedge ref_clk) disable iff (!resetn)
		!s_q.lat[5][B_OE1] |-> !ch_ctrl[1].primary_drive)
		else $error("disabled driver still powered");

	// any driver on, per channel; watched while reset is low
	logic [NUM_CH-1:0] drv_any;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++)
			drv_any[c] = ch_ctrl[c].primary_drive ||
				ch_ctrl[c].secondary_drive;
	end

	a_reset_drive: assert property (@(posedge ref_clk)
		!resetn |-> drv_any == '0)
		else $error("driver on during reset");

	sequence s_taken;
		(avs_read || avs_write) && s_q.st == ST_IDLE;
	endsequence

	sequence s_gl_dyn_wr;
		avs_write && s_q.st == ST_IDLE &&
		avs_address == ADDR_W'(IDX_GL_DYN);
	endsequence

	a_bus_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_taken |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");

	a_force_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_gl_dyn_wr and (avs_writedata[B_GLEN] &&
		s_q.lat[IDX_MASK][B_RFEN])
		|=> s_q.lat[5][B_RFEN] == $past(avs_writedata[B_RFEN]))
		else $error("forced global write not applied");

	a_glen_keep: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_gl_dyn_wr |=> $stable(s_q.lat[2][B_GLEN]))
		else $error("global write changed participation");

	a_ch_indep: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_dyn_wr(0) |=> $stable(s_q.lat[5]))
		else $error("channel write reached another channel");

	a_pend_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[1].recenter_pulse |-> !s_q.rc_pend[1])
		else $error("recenter still pending after pulse");

	a_rx_pwr_ch3: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[3].rx_power == s_q.lat[11][B_RXPWR])
		else $error("channel three rx power mismatch");

	a_ddr_cap: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[0].ddr_capture |-> ch_ctrl[0].txclk_double)
		else $error("ddr capture without rate set");
	a_logic_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[1].channel_logic_on ==
		(ch_ctrl[1].primary_drive || ch_ctrl[1].secondary_drive))
		else $error("channel logic power mismatch");
	a_recenter_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_dyn_wr(0) and (s_q.lat[IDX_MASK][B_PABRST] &&
		!avs_writedata[B_PABRST]) |=> s_q.rc_pend[0])
		else $error("recenter not queued");
	a_recenter_once: assert property (@(posedge ref_clk) disable iff (!resetn)
		ch_ctrl[0].recenter_pulse |=> !ch_ctrl[0].recenter_pulse)
		else $error("recenter pulse too long");
	a_self_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_q.rc_pend[2] |-> s_q.lat[8][B_PABRST])
		else $error("recenter latch not self cleared");
	a_rx_power: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(s_q.lat[5][B_RXPWR]) |=> ch_ctrl[1].rx_power)
		else $error("rx power not following latch");
	a_excluded: assert property (@(posedge ref_clk) disable iff (!resetn)
		avs_write && s_q.st == ST_IDLE && avs_address == ADDR_W'(IDX_GL_DYN)
		&& !avs_writedata[B_GLEN] && !s_q.lat[5][B_GLEN]
		|=> $stable(s_q.lat[5]))
		else $error("excluded bank changed by global write");

endmodule

// ===== testbench/scl_host_model.sv
/*
 * host model: avalon-mm master that writes and reads the latch bank.
 * assumes one clock and a slave that answers through waitrequest.
 */
`timescale 1ns/1ps

module scl_host_model
	import scl_pkg::*;
(
	// clock
	input  wire logic         ref_clk,
	// avalon-mm master
	output logic [ADDR_W-1:0] avs_address,
	output logic              avs_read,
	output logic              avs_write,
	output logic [31:0]       avs_writedata,
	input  wire logic [31:0]  avs_readdata,
	input  wire logic         avs_waitrequest,
	input  wire logic [1:0]   avs_response
);
	initial begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
	end

	// ==========================================================
	// one transfer, held until waitrequest is sampled low
	task automatic xfer(input logic [5:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		// only the bench watchdog ends a hung wait
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		r = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule

// ===== testbench/scl_config_latches_bench.sv
/*
 * bench for the latch bank: int latch model against the design.
 * assumes a 125 mhz clock and the host model on the bus.
 */
`timescale 1ns/1ps

module scl_config_latches_bench
	import scl_pkg::*;
;
	logic                      ref_clk;
	logic                      resetn;
	logic [ADDR_W-1:0]         avs_address;
	logic                      avs_read;
	logic                      avs_write;
	logic [31:0]               avs_writedata;
	logic [31:0]               avs_readdata;
	logic                      avs_waitrequest;
	logic [1:0]                avs_response;
	logic [NUM_CH-1:0]         tx_input_clock;
	logic [NUM_CH-1:0]         speed_range_select;
	scl_ch_ctrl_t [NUM_CH-1:0] ch_ctrl;
	logic [31:0]               q;
	logic [1:0]                r;
	int                        fails;
	int                        comparisons;
	int                        d;
	int                        lat[16];
	int                        cnt[4];

	scl_config_latches i_dut(.ref_clk(ref_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .tx_input_clock(tx_input_clock),
		.speed_range_select(speed_range_select), .ch_ctrl(ch_ctrl));
	scl_host_model i_host(.ref_clk(ref_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response));

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	// ==========================================================
	// helpers
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(int a, int v);
		i_host.xfer(6'(a), 1'b1, 32'(v), q, r);
		chk("write response", 32'(RESP_OK), 32'(r));
	endtask

	function automatic scl_ch_ctrl_t ex(int c);
		scl_ch_ctrl_t e;
		logic [7:0] t;
		logic [7:0] y;
		t = 8'(lat[3*c+1]);
		y = 8'(lat[3*c+2]);
		e.pll_mult = t[B_TXRATE] ? MULT_HIGH : MULT_LOW;
		e.txclk_double = t[B_TXRATE];
		e.ddr_capture = t[B_TXRATE] & t[B_TXCKSEL];
		e.framer_enable = y[B_RFEN];
		e.rx_power = y[B_RXPWR];
		e.rx_selftest_en = !y[B_RXST];
		e.tx_selftest_en = !y[B_TXST];
		e.primary_drive = y[B_OE1];
		e.secondary_drive = y[B_OE2];
		e.channel_logic_on = y[B_OE1] | y[B_OE2];
		e.recenter_pulse = 1'b0;
		e.speed_conflict = t[B_TXRATE] & !speed_range_select[c];
		return e;
	endfunction

	task automatic mreset();
		for (int i = 0; i < 16; i++) begin
			lat[i] = (i > 11) ? 0 : (i % 3 == 0) ? 'hbf :
				(i % 3 == 1) ? 'had : 'hb3;
		end
		lat[15] = 'hff;
	endtask

	// control outputs, then every channel latch and the mask read back
	task automatic chkall(string n);
		repeat (4) @(posedge ref_clk);
		for (int c = 0; c < 4; c++) begin
			chk("ch_ctrl", 32'(ex(c)), 32'(ch_ctrl[c]));
		end
		for (int i = 0; i < 16; i++) begin
			if (i < 12 || i == 15) begin
				i_host.xfer(6'(i), 1'b0, '0, q, r);
				chk("readback", 32'(lat[i]), q);
			end
		end
		$display("test %s done", n);
	endtask

	task automatic stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#100_000;
		fails++;
		stop_test();
	end

	// ==========================================================
	// tests
	initial begin
		resetn = 1'b0;
		tx_input_clock = '0;
		speed_range_select = '1;
		d = $urandom(32'hdca6f6eb);
		mreset();
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		chkall("reset");
		// some channels get rate set with speed low on purpose
		speed_range_select <= 4'($urandom);
		for (int c = 0; c < 4; c++) begin
			lat[3*c+1] = $urandom & 'hff;
			wr(3*c+1, lat[3*c+1]);
			lat[3*c+2] = ($urandom & 'hff) | 2;
			wr(3*c+2, lat[3*c+2]);
		end
		chkall("channel");
		lat[5] = 'hc6;
		wr(5, lat[5]);
		d = ($urandom & 'hfc) | 2;
		wr(14, d);
		for (int c = 0; c < 4; c++) begin
			if (lat[3*c+2] & 1)
				lat[3*c+2] = (lat[3*c+2] & 1) | (d & 'hfe);
		end
		chkall("global");
		for (int k = 0; k < 2; k++) begin
			d = k ? 'h0f : ($urandom & 'hff) | 3;
			wr(14, d);
			for (int c = 0; c < 4; c++)
				lat[3*c+2] = (lat[3*c+2] & 1) | (d & 'hfe) | 2;
		end
		chkall("force");
		for (int c = 0; c < 4; c++) begin
			wr(3*c+2, lat[3*c+2] & 'hfd);
			tx_input_clock[c] <= 1'b1;
			cnt = '{0, 0, 0, 0};
			for (int i = 0; i < 24; i++) begin
				@(posedge ref_clk);
				if (i == 6)
					tx_input_clock[c] <= 1'b0;
				for (int k = 0; k < 4; k++)
					if (ch_ctrl[k].recenter_pulse === 1'b1)
						cnt[k]++;
			end
			for (int k = 0; k < 4; k++)
				chk("recenter", 32'(k == c), 32'(cnt[k]));
		end
		chkall("recenter");
		i_host.xfer(6'h2c, 1'b0, '0, q, r);
		chk("decode resp", 32'(RESP_DECERR), 32'(r));
		chk("decode data", UNMAPPED_RD, q);
		i_host.xfer(6'h31, 1'b1, 32'h0000_00ff, q, r);
		chk("decode resp", 32'(RESP_DECERR), 32'(r));
		i_host.xfer(ADDR_STATUS, 1'b0, '0, q, r);
		d = 0;
		for (int c = 0; c < 4; c++) begin
			d |= (((lat[3*c+2] >> 2) | (lat[3*c+2] >> 3)) & 1) << (4 + c);
			d |= ((lat[3*c+1] >> 1) & 1 &
				int'(!speed_range_select[c])) << (8 + c);
		end
		chk("status", 32'(d), q);
		chkall("unmapped");
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		for (int c = 0; c < 4; c++)
			chk("drive", '0, 32'({ch_ctrl[c].primary_drive,
				ch_ctrl[c].secondary_drive}));
		resetn <= 1'b1;
		mreset();
		chkall("second reset");
		stop_test();
	end
endmodule
